/* File: rtl/seq_params.svh */
// constants for the receiver restart logic and the mode sequencer
// assumes a 10 MHz pclk and an APB master with 32-bit data
//
// Behaviour
// - keep-oscillator restart when frequency untouched
// - relock restart after correction or frequency change
// - restart request ignored unless mode ready
// - auto-restart 00 means no automatic restart
// - auto-restart 01 waits empty FIFO, then delay
// - auto-restart 10 adds synthesizer lock delay
// - collision enable restarts on signal jump
// - collision threshold compared in 1 dB steps
// - start from sleep/standby, remember initial mode
// - stop bit forces sequencer off at once
// - sequencer only in FSK/OOK modulation
// - low-power to off restores initial mode
// - idle holds standby/sleep, leaves on timer one
// - transmit state transmitter on, receive receiver on
// - packet state keeps receiver on, packet held
// - low-power selection is transitory: off or idle
// - any of three timeouts is receive timeout
// - start transition field selects first state
// - low-power choice 0 off, 1 idle
// - timer tick from two-bit resolution times coefficient
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

`define OFS_OP_MODE 8'h00
`define OFS_RX_CONFIG 8'h04
`define OFS_SYNC_CONFIG 8'h08
`define OFS_SEQ_CONFIG1 8'h0c
`define OFS_SEQ_CONFIG2 8'h10
`define OFS_TIMER_RES 8'h14
`define OFS_TIMER1_COEF 8'h18
`define OFS_TIMER2_COEF 8'h1c
`define OFS_STATUS 8'h20

// op mode
`define OPM_LONG_RANGE 7
// receiver config
`define RXC_COLL_EN 7
`define RXC_KEEP_LO 6
`define RXC_RELOCK_LO 5
`define RXC_AFC_EN 4
`define RXC_THR_LSB 8
// sync config
`define SYC_AUTO_LSB 0
`define SYC_DELAY_LSB 8
// sequencer config one
`define SQ1_START 7
`define SQ1_STOP 6
`define SQ1_IDLE_SEL 5
`define SQ1_FROM_START_LSB 3
`define SQ1_LOW_POWER 2
`define SQ1_FROM_IDLE 1
`define SQ1_FROM_TX 0
// sequencer config two
`define SQ2_FROM_RX_LSB 0
`define SQ2_FROM_RXTO_LSB 3
`define SQ2_FROM_PKT_LSB 5

`define OP_MODE_RESET 3'h1
`define CLK_PERIOD_NS 100
`define TICK_64US_NS 64000
`define TICK_4MS_US 4100
`define TICK_262MS_MS 262
`define TICK_64US_CYC (`TICK_64US_NS / `CLK_PERIOD_NS)
`define TICK_4MS_CYC (`TICK_4MS_US * 1000 / `CLK_PERIOD_NS)
`define TICK_262MS_CYC (`TICK_262MS_MS * 1000000 / `CLK_PERIOD_NS)
// extra lock wait in 64 us ticks
`define LOCK_EXTRA_TICKS 9'h010

`endif

/* File: rtl/seq_pkg.sv */
// types for the restart logic and the mode sequencer
// assumes the constants of seq_params.svh
package seq_pkg;

  typedef enum logic [7:0] {
    SEQ_OFF = 8'h01,
    SEQ_IDLE = 8'h02,
    SEQ_TX = 8'h04,
    SEQ_RX = 8'h08,
    SEQ_PKT = 8'h10,
    SEQ_LPSEL = 8'h20,
    SEQ_RXTO = 8'h40,
    SEQ_WAIT_FIFO = 8'h80
  } seq_state_t;

  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0,
    MODE_STDBY = 3'h1,
    MODE_FSTX = 3'h2,
    MODE_TX = 3'h3,
    MODE_FSRX = 3'h4,
    MODE_RX = 3'h5
  } chip_mode_t;

endpackage : seq_pkg

/* File: rtl/seq_tick_gen.sv */
// periodic one-cycle enable pulse every PERIOD pclk cycles
// assumes PERIOD below 2^22
`timescale 1ns/1ps
module seq_tick_gen #(
  parameter int unsigned PERIOD = 640
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  localparam logic [21:0] LAST = 22'(PERIOD - 1);
  logic [21:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 22'h000000;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_reg == LAST);
      cnt_reg <= (cnt_reg == LAST) ? 22'h000000 : cnt_reg + 22'h000001;
    end
  end
endmodule : seq_tick_gen

/* File: rtl/seq_timer.sv */
// one sequencer timer: fires after coef ticks of the selected resolution
// assumes tick is a one-cycle enable from a shared divider
`timescale 1ns/1ps
module seq_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [1:0] res,
  input wire logic [7:0] coef,
  input wire logic start,
  input wire logic abort,
  output logic fire
);
  logic run_reg;
  logic [7:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      cnt_reg <= 8'h00;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (abort) begin
        run_reg <= 1'b0;
      end else if (start) begin
        // resolution 00 leaves the timer disabled
        run_reg <= (res != 2'h0);
        cnt_reg <= 8'h00;
      end else if (run_reg && tick) begin
        // coefficient 0 behaves as 1, never an endless wait
        if (cnt_reg + 8'h01 >= coef) begin
          fire <= 1'b1;
          run_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end
endmodule : seq_timer

/* File: rtl/rx_restart_and_mode_sequencer.sv */
// receiver restart control and top level mode sequencer with APB registers
// assumes event inputs come from logic on pclk, one-cycle pulses
`timescale 1ns/1ps
`include "seq_params.svh"
module rx_restart_and_mode_sequencer #(
  parameter int unsigned TICK_4MS_CYCLES = `TICK_4MS_CYC,
  parameter int unsigned TICK_262MS_CYCLES = `TICK_262MS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_ready_flag,
  input wire logic payload_ready_event,
  input wire logic fifo_empty,
  input wire logic fifo_level_event,
  input wire logic packet_sent_event,
  input wire logic crc_ok_event,
  input wire logic rssi_event,
  input wire logic sync_match_event,
  input wire logic preamble_event,
  input wire logic timeout_signal_level,
  input wire logic timeout_preamble,
  input wire logic timeout_sync_word,
  input wire logic rssi_valid,
  input wire logic [7:0] rssi_strength,
  output logic [2:0] chip_mode,
  output logic long_range_sel,
  output logic rx_restart_keep,
  output logic rx_restart_relock,
  output logic seq_running
);
  seq_pkg::seq_state_t state_reg;
  seq_pkg::seq_state_t state_next;

  logic afc_en_reg, coll_en_reg, idle_sel_reg, low_power_choice, from_idle_reg, from_tx_reg;
  logic [7:0] coll_thr_reg, ipd_reg, t1_coef_reg, t2_coef_reg, base_reg;
  logic [1:0] auto_sel_reg, from_start_reg, from_rxto_reg, t1_res_reg, t2_res_reg;
  logic [2:0] from_rx_reg, from_pkt_reg, init_mode_reg;
  logic armed_reg, delay_run_reg;
  logic [8:0] delay_cnt_reg;
  logic tick_64us, tick_4ms, tick_262ms, t1_fire, t2_fire;

  function automatic logic pick_tick(input logic [1:0] res, input logic a, input logic b,
                                     input logic c);
    unique case (res)
      2'h1: pick_tick = a;
      2'h2: pick_tick = b;
      2'h3: pick_tick = c;
      default: pick_tick = 1'b0;
    endcase
  endfunction : pick_tick

  // apb: one wait-free access, answer in the first access cycle
  logic access, wr, hit;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign hit = (paddr <= `OFS_STATUS) && (paddr[1:0] == 2'h0);

  function automatic logic wr_at(input logic w, input logic [7:0] a, input logic [7:0] ofs);
    wr_at = w && (a == ofs);
  endfunction : wr_at

  logic wr_op, wr_rxc, wr_sq1;
  assign wr_op = wr_at(wr, paddr, `OFS_OP_MODE);
  assign wr_rxc = wr_at(wr, paddr, `OFS_RX_CONFIG);
  assign wr_sq1 = wr_at(wr, paddr, `OFS_SEQ_CONFIG1);

  logic start_wr, stop_wr, start_ok, start_acc;
  assign start_wr = wr_sq1 && pwdata[`SQ1_START];
  // stop takes priority if a host ever sets both
  assign stop_wr = wr_sq1 && pwdata[`SQ1_STOP];
  assign start_ok = !long_range_sel &&
      (chip_mode == seq_pkg::MODE_SLEEP || chip_mode == seq_pkg::MODE_STDBY);
  assign start_acc = (state_reg == seq_pkg::SEQ_OFF) && start_wr && !stop_wr && start_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `OFS_OP_MODE: prdata <= {24'h000000, long_range_sel, 4'h0, chip_mode};
          `OFS_RX_CONFIG: prdata <= {16'h0000, coll_thr_reg, coll_en_reg, 2'h0,
                                     afc_en_reg, 4'h0};
          `OFS_SYNC_CONFIG: prdata <= {16'h0000, ipd_reg, 6'h00, auto_sel_reg};
          `OFS_SEQ_CONFIG1: prdata <= {24'h000000, 2'h0, idle_sel_reg, from_start_reg,
                                       low_power_choice, from_idle_reg, from_tx_reg};
          `OFS_SEQ_CONFIG2: prdata <= {24'h000000, from_pkt_reg, from_rxto_reg, from_rx_reg};
          `OFS_TIMER_RES: prdata <= {28'h0000000, t2_res_reg, t1_res_reg};
          `OFS_TIMER1_COEF: prdata <= {24'h000000, t1_coef_reg};
          `OFS_TIMER2_COEF: prdata <= {24'h000000, t2_coef_reg};
          `OFS_STATUS: prdata <= {16'h0000, state_reg, 4'h0, armed_reg, delay_run_reg,
                                  mode_ready_flag, seq_running};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // configuration; trigger bits are not stored and read back 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_range_sel <= 1'b0;
      {coll_en_reg, afc_en_reg, coll_thr_reg} <= {2'h0, 8'h00};
      {auto_sel_reg, ipd_reg} <= {2'h0, 8'h00};
      {idle_sel_reg, from_start_reg, low_power_choice, from_idle_reg, from_tx_reg} <= 6'h00;
      {from_pkt_reg, from_rxto_reg, from_rx_reg} <= 8'h00;
      {t2_res_reg, t1_res_reg, t1_coef_reg, t2_coef_reg} <= {4'h0, 8'h00, 8'h00};
    end else begin
      if (wr_op && state_reg == seq_pkg::SEQ_OFF) begin
        long_range_sel <= pwdata[`OPM_LONG_RANGE];
      end
      if (wr_rxc) begin
        coll_en_reg <= pwdata[`RXC_COLL_EN];
        afc_en_reg <= pwdata[`RXC_AFC_EN];
        coll_thr_reg <= pwdata[`RXC_THR_LSB +: 8];
      end
      if (wr_at(wr, paddr, `OFS_SYNC_CONFIG)) begin
        auto_sel_reg <= pwdata[`SYC_AUTO_LSB +: 2];
        ipd_reg <= pwdata[`SYC_DELAY_LSB +: 8];
      end
      if (wr_sq1) begin
        idle_sel_reg <= pwdata[`SQ1_IDLE_SEL];
        from_start_reg <= pwdata[`SQ1_FROM_START_LSB +: 2];
        low_power_choice <= pwdata[`SQ1_LOW_POWER];
        from_idle_reg <= pwdata[`SQ1_FROM_IDLE];
        from_tx_reg <= pwdata[`SQ1_FROM_TX];
      end
      if (wr_at(wr, paddr, `OFS_SEQ_CONFIG2)) begin
        from_rx_reg <= pwdata[`SQ2_FROM_RX_LSB +: 3];
        from_rxto_reg <= pwdata[`SQ2_FROM_RXTO_LSB +: 2];
        from_pkt_reg <= pwdata[`SQ2_FROM_PKT_LSB +: 3];
      end
      if (wr_at(wr, paddr, `OFS_TIMER_RES)) begin
        {t2_res_reg, t1_res_reg} <= pwdata[3:0];
      end
      if (wr_at(wr, paddr, `OFS_TIMER1_COEF)) begin
        t1_coef_reg <= pwdata[7:0];
      end
      if (wr_at(wr, paddr, `OFS_TIMER2_COEF)) begin
        t2_coef_reg <= pwdata[7:0];
      end
    end
  end

  seq_tick_gen #(.PERIOD(`TICK_64US_CYC)) u_tick_64us (
    .pclk(pclk), .presetn(presetn), .tick(tick_64us));
  seq_tick_gen #(.PERIOD(TICK_4MS_CYCLES)) u_tick_4ms (
    .pclk(pclk), .presetn(presetn), .tick(tick_4ms));
  seq_tick_gen #(.PERIOD(TICK_262MS_CYCLES)) u_tick_262ms (
    .pclk(pclk), .presetn(presetn), .tick(tick_262ms));

  // timers cycle regardless of state, but stop with the sequencer
  logic timers_abort;
  assign timers_abort = (state_reg == seq_pkg::SEQ_OFF) && !start_acc;

  seq_timer u_timer1 (
    .pclk(pclk), .presetn(presetn),
    .tick(pick_tick(t1_res_reg, tick_64us, tick_4ms, tick_262ms)),
    .res(t1_res_reg), .coef(t1_coef_reg), .start(start_acc || t2_fire),
    .abort(timers_abort), .fire(t1_fire));
  seq_timer u_timer2 (
    .pclk(pclk), .presetn(presetn),
    .tick(pick_tick(t2_res_reg, tick_64us, tick_4ms, tick_262ms)),
    .res(t2_res_reg), .coef(t2_coef_reg), .start(t1_fire),
    .abort(timers_abort), .fire(t2_fire));

  logic rx_timeout;
  assign rx_timeout = timeout_signal_level || timeout_preamble || timeout_sync_word;

  always_comb begin
    state_next = state_reg;
    if (stop_wr || (long_range_sel && state_reg != seq_pkg::SEQ_OFF)) begin
      state_next = seq_pkg::SEQ_OFF;
    end else begin
      unique case (state_reg)
        seq_pkg::SEQ_OFF: if (start_acc) begin
          unique case (pwdata[`SQ1_FROM_START_LSB +: 2])
            2'h0: state_next = seq_pkg::SEQ_LPSEL;
            2'h1: state_next = seq_pkg::SEQ_RX;
            2'h2: state_next = seq_pkg::SEQ_TX;
            default: state_next = seq_pkg::SEQ_WAIT_FIFO;
          endcase
        end
        seq_pkg::SEQ_WAIT_FIFO: if (fifo_level_event) begin
          state_next = seq_pkg::SEQ_TX;
        end
        seq_pkg::SEQ_IDLE: if (t1_fire) begin
          state_next = from_idle_reg ? seq_pkg::SEQ_RX : seq_pkg::SEQ_TX;
        end
        seq_pkg::SEQ_TX: if (packet_sent_event) begin
          state_next = from_tx_reg ? seq_pkg::SEQ_RX : seq_pkg::SEQ_LPSEL;
        end
        seq_pkg::SEQ_RX: begin
          if (t2_fire) begin
            state_next = seq_pkg::SEQ_LPSEL;
          end else if (rx_timeout) begin
            state_next = seq_pkg::SEQ_RXTO;
          end else begin
            unique case (from_rx_reg)
              3'h1: if (payload_ready_event) state_next = seq_pkg::SEQ_PKT;
              3'h2: if (payload_ready_event) state_next = seq_pkg::SEQ_LPSEL;
              3'h3: begin
                if (crc_ok_event) state_next = seq_pkg::SEQ_PKT;
                else if (payload_ready_event) state_next = seq_pkg::SEQ_RXTO;
              end
              3'h4: if (rssi_event) state_next = seq_pkg::SEQ_OFF;
              3'h5: if (sync_match_event) state_next = seq_pkg::SEQ_OFF;
              3'h6: if (preamble_event) state_next = seq_pkg::SEQ_OFF;
              default: state_next = seq_pkg::SEQ_RX;
            endcase
          end
        end
        seq_pkg::SEQ_RXTO: begin
          unique case (from_rxto_reg)
            2'h0: state_next = seq_pkg::SEQ_RX;
            2'h1: state_next = seq_pkg::SEQ_TX;
            2'h2: state_next = seq_pkg::SEQ_LPSEL;
            default: state_next = seq_pkg::SEQ_OFF;
          endcase
        end
        seq_pkg::SEQ_PKT: begin
          unique case (from_pkt_reg)
            3'h1: if (fifo_empty) state_next = seq_pkg::SEQ_TX;
            3'h2: state_next = seq_pkg::SEQ_LPSEL;
            3'h3, 3'h4: state_next = seq_pkg::SEQ_RX;
            default: state_next = seq_pkg::SEQ_OFF;
          endcase
        end
        seq_pkg::SEQ_LPSEL:
          state_next = low_power_choice ? seq_pkg::SEQ_IDLE : seq_pkg::SEQ_OFF;
        default: state_next = seq_pkg::SEQ_OFF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= seq_pkg::SEQ_OFF;
      seq_running <= 1'b0;
    end else begin
      state_reg <= state_next;
      seq_running <= (state_next != seq_pkg::SEQ_OFF);
    end
  end

  // chip mode: host writes only while off, sequencer owns it otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_mode <= `OP_MODE_RESET;
      init_mode_reg <= `OP_MODE_RESET;
    end else begin
      if (start_acc) begin
        init_mode_reg <= chip_mode;
      end
      unique case (state_next)
        seq_pkg::SEQ_IDLE: chip_mode <= idle_sel_reg ? seq_pkg::MODE_SLEEP
                                                     : seq_pkg::MODE_STDBY;
        seq_pkg::SEQ_TX: chip_mode <= seq_pkg::MODE_TX;
        seq_pkg::SEQ_RX, seq_pkg::SEQ_PKT: chip_mode <= seq_pkg::MODE_RX;
        seq_pkg::SEQ_OFF: begin
          if (state_reg == seq_pkg::SEQ_LPSEL) begin
            chip_mode <= init_mode_reg;
          end else if (wr_op && state_reg == seq_pkg::SEQ_OFF) begin
            chip_mode <= pwdata[2:0];
          end
        end
        default: chip_mode <= chip_mode;
      endcase
    end
  end

  // restart requests; relock when frequency may have moved
  logic in_rx, man_keep, man_relock, coll_hit, auto_done, rxto_restart, pkt_relock;
  assign in_rx = (chip_mode == seq_pkg::MODE_RX);
  assign man_keep = wr_rxc && pwdata[`RXC_KEEP_LO] && mode_ready_flag && in_rx;
  assign man_relock = wr_rxc && pwdata[`RXC_RELOCK_LO] && mode_ready_flag && in_rx;
  // 9-bit sum so a high baseline cannot wrap into a false hit
  assign coll_hit = coll_en_reg && in_rx && rssi_valid &&
      ({1'b0, rssi_strength} > ({1'b0, base_reg} + {1'b0, coll_thr_reg}));
  assign auto_done = delay_run_reg && tick_64us && (delay_cnt_reg == 9'h000);
  assign rxto_restart = (state_reg == seq_pkg::SEQ_RXTO) && (state_next == seq_pkg::SEQ_RX);
  assign pkt_relock = (state_reg == seq_pkg::SEQ_PKT) && (state_next == seq_pkg::SEQ_RX) &&
      (from_pkt_reg == 3'h3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_reg <= 8'h00;
    end else if (rssi_valid) begin
      base_reg <= rssi_strength;
    end
  end

  // auto restart: arm on payload ready, wait for empty FIFO, then delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
      delay_run_reg <= 1'b0;
      delay_cnt_reg <= 9'h000;
    end else begin
      if (auto_done) begin
        delay_run_reg <= 1'b0;
      end else if (delay_run_reg && tick_64us) begin
        delay_cnt_reg <= delay_cnt_reg - 9'h001;
      end
      // a fresh load wins over the end of a running delay
      if (payload_ready_event && in_rx && auto_sel_reg != 2'h0) begin
        armed_reg <= 1'b1;
      end else if (armed_reg && fifo_empty) begin
        armed_reg <= 1'b0;
        delay_run_reg <= 1'b1;
        delay_cnt_reg <= {1'b0, ipd_reg} +
            ((auto_sel_reg == 2'h2) ? `LOCK_EXTRA_TICKS : 9'h000);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_restart_keep <= 1'b0;
      rx_restart_relock <= 1'b0;
    end else begin
      rx_restart_keep <= man_keep || coll_hit || rxto_restart ||
          (auto_done && auto_sel_reg == 2'h1);
      rx_restart_relock <= man_relock || pkt_relock || (auto_done && auto_sel_reg == 2'h2);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ignore_restart_a: assert property (
    (wr_rxc && !mode_ready_flag && !coll_hit && !rxto_restart && !pkt_relock && !auto_done)
    |=> (!rx_restart_keep && !rx_restart_relock))
    else $error("restart taken without mode ready");
  keep_restart_a: assert property (
    man_keep |=> rx_restart_keep ##1
    (!rx_restart_keep || $past(coll_hit || rxto_restart || auto_done)))
    else $error("keep restart not pulsed");
  relock_restart_a: assert property (
    man_relock |=> rx_restart_relock)
    else $error("relock restart not pulsed");
  auto_off_a: assert property (
    (auto_sel_reg == 2'h0 && !armed_reg) |=> !armed_reg)
    else $error("auto restart armed while off");
  fifo_wait_a: assert property (
    (armed_reg && !fifo_empty && !delay_run_reg) |=> armed_reg && !delay_run_reg)
    else $error("delay began before FIFO empty");
  lock_delay_a: assert property (
    (armed_reg && fifo_empty && !payload_ready_event && auto_sel_reg == 2'h2)
    |=> delay_cnt_reg == {1'b0, $past(ipd_reg)} + `LOCK_EXTRA_TICKS)
    else $error("lock delay missing");
  collision_a: assert property (
    coll_hit |=> rx_restart_keep)
    else $error("collision restart missing");
  stop_off_a: assert property (
    stop_wr |=> state_reg == seq_pkg::SEQ_OFF && !seq_running)
    else $error("stop did not turn sequencer off");
  no_fsk_a: assert property (
    long_range_sel |=> state_reg == seq_pkg::SEQ_OFF)
    else $error("sequencer ran in long range mode");
  idle_mode_a: assert property (
    (state_reg == seq_pkg::SEQ_IDLE && $stable(idle_sel_reg) && $past(state_reg) == state_reg)
    |-> chip_mode == (idle_sel_reg ? seq_pkg::MODE_SLEEP : seq_pkg::MODE_STDBY))
    else $error("idle chip mode wrong");
  lpsel_exit_a: assert property (
    (state_reg == seq_pkg::SEQ_LPSEL && !low_power_choice && !stop_wr && !long_range_sel)
    |=> state_reg == seq_pkg::SEQ_OFF && chip_mode == $past(init_mode_reg))
    else $error("low power exit wrong");
  start_rx_a: assert property (
    (start_acc && pwdata[`SQ1_FROM_START_LSB +: 2] == 2'h1) |=> state_reg == seq_pkg::SEQ_RX &&
    chip_mode == seq_pkg::MODE_RX)
    else $error("start to receive failed");

  start_c: cover property (start_acc ##[1:20] state_reg == seq_pkg::SEQ_RX);
  idle_exit_c: cover property (state_reg == seq_pkg::SEQ_IDLE ##1 state_reg == seq_pkg::SEQ_TX);
  auto_restart_c: cover property (auto_done ##1 rx_restart_relock);
endmodule : rx_restart_and_mode_sequencer

/* File: tb/host_model.sv */
// host microcontroller model: apb master that sets up the block
// assumes callers enter its task from a process synchronous to pclk
`timescale 1ns/1ps
module host_model (
  input wire logic pclk,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    // a real host never combines start with stop
    if (a == 8'h0c && d[7] && d[6]) d[7] = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : host_model

/* File: tb/rx_restart_and_mode_sequencer_test.sv */
// self-checking bench for restart control and mode sequencer
// assumes host_model as apb master, one 10 MHz clock
`timescale 1ns/1ps
module rx_restart_and_mode_sequencer_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic mrdy = 1'b0, fempty = 1'b1, rv = 1'b0;
  // event pulses: payload ready, fifo level, packet sent, crc ok
  logic [3:0] ev = 4'h0;
  logic [2:0] tmo = 3'h0;
  logic [7:0] rs = 8'h00, paddr;
  logic psel, penable, pwrite, pready, pslverr, keep, relock, run, lr;
  logic [31:0] pwdata, prdata, rq;
  logic [2:0] chip_mode;
  logic re;
  int n_fail = 0, total_checks = 0, n_keep = 0, n_relock = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    if (keep === 1'b1) n_keep++;
    if (relock === 1'b1) n_relock++;
  end
  host_model host_model_i (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rx_restart_and_mode_sequencer #(.TICK_4MS_CYCLES(50), .TICK_262MS_CYCLES(100))
    rx_restart_and_mode_sequencer_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_ready_flag(mrdy), .payload_ready_event(ev[0]),
    .fifo_empty(fempty), .fifo_level_event(ev[1]), .packet_sent_event(ev[2]),
    .crc_ok_event(ev[3]), .rssi_event(1'b0), .sync_match_event(1'b0),
    .preamble_event(1'b0), .timeout_signal_level(tmo[0]), .timeout_preamble(tmo[1]),
    .timeout_sync_word(tmo[2]), .rssi_valid(rv), .rssi_strength(rs),
    .chip_mode(chip_mode), .long_range_sel(lr), .rx_restart_keep(keep),
    .rx_restart_relock(relock), .seq_running(run));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_model_i.xfer(1'b1, a, d, rq, re);
    repeat (3) @(posedge pclk);
  endtask : wr
  task automatic samp(input logic [7:0] v);
    rv <= 1'b1;
    rs <= v;
    @(posedge pclk);
    rv <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : samp
  task automatic kick(input int k);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev[k] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : kick
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wr(8'h00, 32'h5);
    chk(chip_mode, 32'h5);
    wr(8'h04, 32'h40);
    chk(n_keep, 0);
    mrdy <= 1'b1;
    wr(8'h04, 32'h40);
    chk(n_keep, 1);
    wr(8'h04, 32'h20);
    chk(n_relock, 1);
    $display("manual restart done");
    samp(8'h10);
    wr(8'h04, 32'h0580);
    samp(8'h15);
    chk(n_keep + n_relock, 2);
    samp(8'h1b);
    chk(n_keep + n_relock, 3);
    wr(8'h04, 32'h0);
    $display("collision done");
    // select 00, then 01 with one tick, then 10 adding sixteen ticks
    wr(8'h08, 32'h0);
    kick(0);
    repeat (1500) @(posedge pclk);
    chk(n_keep + n_relock, 3);
    wr(8'h08, 32'h0101);
    fempty <= 1'b0;
    kick(0);
    repeat (1500) @(posedge pclk);
    chk(n_keep, 2);
    fempty <= 1'b1;
    repeat (1500) @(posedge pclk);
    chk(n_keep, 3);
    wr(8'h08, 32'h2);
    kick(0);
    repeat (9000) @(posedge pclk);
    chk(n_relock, 1);
    repeat (3000) @(posedge pclk);
    chk(n_relock, 2);
    wr(8'h08, 32'h0);
    $display("auto restart done");
    wr(8'h00, 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h0c, 32'h88);
    chk({run, chip_mode}, 32'hd);
    for (int i = 0; i < 3; i++) begin
      tmo <= 3'h1 << i;
      @(posedge pclk);
      tmo <= 3'h0;
      repeat (4) @(posedge pclk);
      chk(n_keep, 4 + i);
    end
    wr(8'h0c, 32'h40);
    chk(run, 0);
    // receive, payload to low-power selection, back to sleep
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h2);
    wr(8'h0c, 32'h88);
    kick(0);
    chk({run, chip_mode}, 32'h0);
    // idle in sleep; timer one needs two 64 us ticks, then transmit
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h2);
    wr(8'h0c, 32'ha4);
    chk({run, chip_mode}, 32'h8);
    repeat (1400) @(posedge pclk);
    chk({run, chip_mode}, 32'hb);
    kick(2);
    chk({run, chip_mode}, 32'h8);
    wr(8'h0c, 32'h40);
    wr(8'h0c, 32'h98);
    chk({run, chip_mode}, 32'h8);
    kick(1);
    chk({run, chip_mode}, 32'hb);
    // packet held while the FIFO still has data
    wr(8'h0c, 32'h40);
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h23);
    fempty <= 1'b0;
    wr(8'h0c, 32'h88);
    kick(3);
    host_model_i.xfer(1'b0, 8'h20, 32'h0, rq, re);
    chk(rq, 32'h1003);
    fempty <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({run, chip_mode}, 32'hb);
    wr(8'h0c, 32'h40);
    wr(8'h00, 32'h81);
    wr(8'h0c, 32'h88);
    chk({run, lr}, 32'h1);
    $display("sequencer done");
    host_model_i.xfer(1'b0, 8'h24, 32'h0, rq, re);
    chk({31'h0, re}, 32'h1);
    $display("unmapped done");
    print_verdict;
  end
endmodule : rx_restart_and_mode_sequencer_test
